// ===== verilog/sys_clock_reset_defines.vh
// Register map, field positions and reset values of the clock and reset
// configuration slice. Included by the register bank, its assertions and its bench.
`ifndef SYS_CLOCK_RESET_DEFINES_VH
`define SYS_CLOCK_RESET_DEFINES_VH

// Byte addresses of the registers on the peripheral bus.
`define ADDR_PERIPH_RESET_CTRL   32'h4004_8004
`define ADDR_PLL_CTRL            32'h4004_8008
`define ADDR_PLL_STATUS          32'h4004_800C
`define ADDR_MAIN_OSC_CTRL       32'h4004_8020
`define ADDR_WDOG_OSC_CTRL       32'h4004_8024

// Peripheral reset control fields.
`define PRC_TIMER32_FIRST_BIT    7
`define PRC_DAC_BIT              10
`define PRC_TIMER32_FIRST_RST    1'b1
`define PRC_DAC_RST              1'b1

// PLL control fields.
`define PLL_FB_DIV_LSB           0
`define PLL_FB_DIV_MSB           4
`define PLL_POST_DIV_LSB         5
`define PLL_POST_DIV_MSB         6
`define PLL_FB_DIV_RST           5'h00
`define PLL_POST_DIV_RST         2'h0

// PLL status fields.
`define PLL_LOCK_BIT             0
`define PLL_LOCK_RST             1'b0

// Main oscillator control fields.
`define OSC_BYPASS_BIT           0
`define OSC_RANGE_BIT            1
`define OSC_BYPASS_RST           1'b0
`define OSC_RANGE_RST            1'b0

// Watchdog oscillator control fields.
`define WDOG_DIV_LSB             0
`define WDOG_DIV_MSB             4
`define WDOG_DIV_RST             5'h00

// Value returned for reserved bits and unmapped addresses.
`define READ_ZERO                32'h0000_0000

`endif

// ===== verilog/wdog_osc_divider.v
// Digital stage of the watchdog oscillator: divides a tick stream by
// 2 x (1 + select). Assumes the tick input is a one-cycle pulse in clk.
`timescale 1ns/1ps
`default_nettype none

module wdog_osc_divider #(
    parameter SEL_W = 5
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire [SEL_W-1:0] div_sel,
    input  wire             tick,
    output reg              osc_clk_out
);
    reg [SEL_W-1:0] count_q;

    // The output toggles every (1 + select) ticks, so one full period spans
    // 2 x (1 + select) ticks; a select change applies at once, to the interval in progress.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q     <= {SEL_W{1'b0}};
            osc_clk_out <= 1'b0;
        end else if (tick) begin
            if (count_q >= div_sel) begin
                count_q     <= {SEL_W{1'b0}};
                osc_clk_out <= ~osc_clk_out;
            end else begin
                count_q <= count_q + {{(SEL_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

`default_nettype wire

// ===== verilog/pll_ratio_decode.v
// Registered decode of the PLL divider fields into plain ratios.
// Assumes both fields come from the register bank in the same clock.
`timescale 1ns/1ps
`default_nettype none

module pll_ratio_decode (
    input  wire       clk,
    input  wire       resetn,
    input  wire [4:0] fb_div,
    input  wire [1:0] post_sel,
    output reg  [5:0] fb_ratio,
    output reg  [4:0] post_ratio
);
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fb_ratio   <= 6'h01;
            post_ratio <= 5'h02;
        end else begin
            fb_ratio <= {1'b0, fb_div} + 6'h01;
            case (post_sel)
                2'h0:    post_ratio <= 5'h02;
                2'h1:    post_ratio <= 5'h04;
                2'h2:    post_ratio <= 5'h08;
                2'h3:    post_ratio <= 5'h10;
                default: post_ratio <= 5'h02;
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== verilog/sys_clock_reset_config.v
// Clock and reset configuration register slice with an Avalon-MM slave.
// Assumes a synchronous PLL lock level and a one-cycle oscillator tick.
//
// Function
// - A peripheral reset bit holds its peripheral in reset at 0 and releases it at 1.
// - Bit 7 of the reset control drives the first 32-bit timer reset, active low, reset 1.
// - Bit 10 of the reset control drives the DAC reset, active low, reset 1.
// - PLL control bits 4:0 hold the feedback divider, reset 0, ratio value plus one.
// - PLL control bits 6:5 select P of 1, 2, 4 or 8, reset 0, post division twice P.
// - PLL status bit 0 is read-only, shows lock, and reads 0 after reset.
// - Oscillator control bit 0 resets to 0 and when 1 feeds the PLL from the crystal pin.
// - Oscillator control bit 1 resets to 0 for the 1-20 MHz range, 1 for 15-25 MHz.
// - Oscillator control bits 31:2 are reserved and reset to zero.
// - Watchdog oscillator control bits 4:0 hold the divider select, reset 0.
// - The watchdog divider divides the analog clock by two times one plus the select.
// - The watchdog division spans 2 for select 0 up to 64 for select 31.
`timescale 1ns/1ps
`default_nettype none
`include "sys_clock_reset_defines.vh"

module sys_clock_reset_config (
    input  wire        clk,
    input  wire        resetn,
    input  wire [31:0] address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    input  wire        pll_lock_in,
    input  wire        crystal_in_pin,
    input  wire        osc_clk_in,
    input  wire        wdog_osc_analog_tick,
    output reg         timer32_first_reset_n,
    output reg         dac_reset_n,
    output wire [4:0]  pll_feedback_div,
    output wire [1:0]  pll_post_div_sel,
    output wire [5:0]  pll_feedback_ratio,
    output wire [4:0]  pll_post_ratio,
    output reg         pll_in_clk,
    output wire        osc_bypass,
    output wire        osc_range_sel,
    output wire [4:0]  wdog_osc_div_sel,
    output wire        wdog_osc_clk_out
);
    reg [4:0] pll_fb_q;
    reg [1:0] pll_post_q;
    reg       pll_lock_q;
    reg       osc_bypass_q;
    reg       osc_range_q;
    reg [4:0] wdog_div_q;
    reg       ack_q;
    reg [31:0] rd_d;

    wire req     = read | write;
    // The write lands on the same edge at which the master sees waitrequest low.
    wire wr_take = write & ack_q;

    // One wait state: the read word is built on the first edge and presented
    // while waitrequest is low, so read data never depend on a late address.
    assign waitrequest = req & ~ack_q;

    assign pll_feedback_div = pll_fb_q;
    assign pll_post_div_sel = pll_post_q;
    assign osc_bypass       = osc_bypass_q;
    assign osc_range_sel    = osc_range_q;
    assign wdog_osc_div_sel = wdog_div_q;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read mux; reserved bits and unmapped addresses return zero.
    always @* begin
        rd_d = `READ_ZERO;
        case (address)
            `ADDR_PERIPH_RESET_CTRL: begin
                rd_d[`PRC_TIMER32_FIRST_BIT] = timer32_first_reset_n;
                rd_d[`PRC_DAC_BIT]           = dac_reset_n;
            end
            `ADDR_PLL_CTRL: begin
                rd_d[`PLL_FB_DIV_MSB:`PLL_FB_DIV_LSB]     = pll_fb_q;
                rd_d[`PLL_POST_DIV_MSB:`PLL_POST_DIV_LSB] = pll_post_q;
            end
            `ADDR_PLL_STATUS: begin
                rd_d[`PLL_LOCK_BIT] = pll_lock_q;
            end
            `ADDR_MAIN_OSC_CTRL: begin
                rd_d[`OSC_BYPASS_BIT] = osc_bypass_q;
                rd_d[`OSC_RANGE_BIT]  = osc_range_q;
            end
            `ADDR_WDOG_OSC_CTRL: begin
                rd_d[`WDOG_DIV_MSB:`WDOG_DIV_LSB] = wdog_div_q;
            end
            default: begin
                rd_d = `READ_ZERO;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= `READ_ZERO;
        end else if (read & ~ack_q) begin
            readdata <= rd_d;
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timer32_first_reset_n <= `PRC_TIMER32_FIRST_RST;
            dac_reset_n           <= `PRC_DAC_RST;
            pll_fb_q              <= `PLL_FB_DIV_RST;
            pll_post_q            <= `PLL_POST_DIV_RST;
            osc_bypass_q          <= `OSC_BYPASS_RST;
            osc_range_q           <= `OSC_RANGE_RST;
            wdog_div_q            <= `WDOG_DIV_RST;
        end else if (wr_take) begin
            // only assigned bits are stored; the rest are dropped.
            case (address)
                `ADDR_PERIPH_RESET_CTRL: begin
                    if (byteenable[0]) begin
                        timer32_first_reset_n <= writedata[`PRC_TIMER32_FIRST_BIT];
                    end
                    if (byteenable[1]) begin
                        dac_reset_n <= writedata[`PRC_DAC_BIT];
                    end
                end
                `ADDR_PLL_CTRL: begin
                    if (byteenable[0]) begin
                        pll_fb_q   <= writedata[`PLL_FB_DIV_MSB:`PLL_FB_DIV_LSB];
                        pll_post_q <= writedata[`PLL_POST_DIV_MSB:`PLL_POST_DIV_LSB];
                    end
                end
                `ADDR_MAIN_OSC_CTRL: begin
                    if (byteenable[0]) begin
                        osc_bypass_q <= writedata[`OSC_BYPASS_BIT];
                        osc_range_q  <= writedata[`OSC_RANGE_BIT];
                    end
                end
                `ADDR_WDOG_OSC_CTRL: begin
                    if (byteenable[0]) begin
                        wdog_div_q <= writedata[`WDOG_DIV_MSB:`WDOG_DIV_LSB];
                    end
                end
                default: begin
                    wdog_div_q <= wdog_div_q;
                end
            endcase
        end
    end

    // Lock level is sampled each clock; the status register has no write path.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_lock_q <= `PLL_LOCK_RST;
            pll_in_clk <= 1'b0;
        end else begin
            pll_lock_q <= pll_lock_in;
            pll_in_clk <= osc_bypass_q ? crystal_in_pin : osc_clk_in;
        end
    end

    // The ratios are registered, so they trail the fields by one clock.
    pll_ratio_decode u_pll_ratio (
        .clk        (clk),
        .resetn     (resetn),
        .fb_div     (pll_fb_q),
        .post_sel   (pll_post_q),
        .fb_ratio   (pll_feedback_ratio),
        .post_ratio (pll_post_ratio)
    );

    // five-bit select spans 2 to 64
    wdog_osc_divider #(
        .SEL_W (5)
    ) u_wdog_div (
        .clk         (clk),
        .resetn      (resetn),
        .div_sel     (wdog_div_q),
        .tick        (wdog_osc_analog_tick),
        .osc_clk_out (wdog_osc_clk_out)
    );
endmodule

`default_nettype wire

// ===== tb/sys_clock_reset_sva.sv
// Assertions on the ports of the clock and reset configuration slice.
// Assumes it is bound to the top module, whose ports share these names.
`timescale 1ns/1ps
`default_nettype none
`include "sys_clock_reset_defines.vh"
module sys_clock_reset_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [31:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        timer32_first_reset_n,
    input wire logic        dac_reset_n,
    input wire logic [4:0]  pll_feedback_div,
    input wire logic [1:0]  pll_post_div_sel,
    input wire logic [5:0]  pll_feedback_ratio,
    input wire logic [4:0]  pll_post_ratio,
    input wire logic        osc_bypass,
    input wire logic        osc_range_sel,
    input wire logic [4:0]  wdog_osc_div_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic wr_ok = write && !waitrequest;
    property p_t32;
        wr_ok && address == `ADDR_PERIPH_RESET_CTRL && byteenable[0]
            |=> timer32_first_reset_n == $past(writedata[7]);
    endproperty
    a_t32: assert property (p_t32) else $error("timer reset bit wrong");
    property p_dac;
        wr_ok && address == `ADDR_PERIPH_RESET_CTRL && byteenable[1]
            |=> dac_reset_n == $past(writedata[10]);
    endproperty
    a_dac: assert property (p_dac) else $error("dac reset bit wrong");
    property p_fb;
        pll_feedback_ratio == $past(pll_feedback_div) + 6'h1;
    endproperty
    a_fb: assert property (p_fb) else $error("feedback ratio wrong");
    property p_post;
        pll_post_ratio == (5'h2 << $past(pll_post_div_sel));
    endproperty
    a_post: assert property (p_post) else $error("post ratio wrong");
    property p_byp;
        wr_ok && address == `ADDR_MAIN_OSC_CTRL |=> osc_bypass == $past(writedata[0]);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass bit wrong");
    property p_rng;
        wr_ok && address == `ADDR_MAIN_OSC_CTRL |=> osc_range_sel == $past(writedata[1]);
    endproperty
    a_rng: assert property (p_rng) else $error("range bit wrong");
    property p_wsel;
        wr_ok && address == `ADDR_WDOG_OSC_CTRL |=> wdog_osc_div_sel == $past(writedata[4:0]);
    endproperty
    a_wsel: assert property (p_wsel) else $error("watchdog select wrong");
    property p_rsvd;
        read && !waitrequest |-> (readdata & ((address == `ADDR_PERIPH_RESET_CTRL)
            ? 32'hFFFF_FB7F : 32'hFFFF_FF80)) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the clock and reset configuration slice.
// Assumes the design and its defines header are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sys_clock_reset_defines.vh"
module tb_top;
    logic        clk = 0, resetn = 0, read = 0, write = 0, pll_lock_in = 0;
    logic        crystal_in_pin = 0, osc_clk_in = 0, wdog_osc_analog_tick = 0;
    logic        waitrequest, timer32_first_reset_n, dac_reset_n, pll_in_clk;
    logic        osc_bypass, osc_range_sel, wdog_osc_clk_out;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] address = '0, writedata = '0, readdata, q;
    logic [4:0]  pll_feedback_div, pll_post_ratio, wdog_osc_div_sel, m;
    logic [1:0]  pll_post_div_sel;
    logic [5:0]  pll_feedback_ratio;
    int          err_total = 0, check_count = 0, cyc = 0;
    sys_clock_reset_config i_dut (
        .clk                   (clk),
        .resetn                (resetn),
        .address               (address),
        .read                  (read),
        .write                 (write),
        .byteenable            (byteenable),
        .writedata             (writedata),
        .readdata              (readdata),
        .waitrequest           (waitrequest),
        .pll_lock_in           (pll_lock_in),
        .crystal_in_pin        (crystal_in_pin),
        .osc_clk_in            (osc_clk_in),
        .wdog_osc_analog_tick  (wdog_osc_analog_tick),
        .timer32_first_reset_n (timer32_first_reset_n),
        .dac_reset_n           (dac_reset_n),
        .pll_feedback_div      (pll_feedback_div),
        .pll_post_div_sel      (pll_post_div_sel),
        .pll_feedback_ratio    (pll_feedback_ratio),
        .pll_post_ratio        (pll_post_ratio),
        .pll_in_clk            (pll_in_clk),
        .osc_bypass            (osc_bypass),
        .osc_range_sel         (osc_range_sel),
        .wdog_osc_div_sel      (wdog_osc_div_sel),
        .wdog_osc_clk_out      (wdog_osc_clk_out)
    );
    initial forever #2 clk = ~clk;
    task summarize;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Called right after a rising edge; holds the request until waitrequest
    // is sampled low at a rising edge, then lets one edge pass after release
    // so that written fields have settled before the caller checks them.
    task bus(input logic rw, input logic [31:0] a, d, input logic [3:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !rw;
        write <= rw;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
        @(posedge clk);
    endtask
    task wr(input logic [31:0] a, d, input logic [3:0] be = 4'hF);
        bus(1, a, d, be);
    endtask
    task rd(input logic [31:0] a, e);
        bus(0, a, '0, 4'hF);
        chk(q, e);
    endtask
    task t_reset;
        wr(`ADDR_WDOG_OSC_CTRL, 32'h0000_0020);
        rd(`ADDR_PERIPH_RESET_CTRL, 32'h0000_0480);
        rd(`ADDR_PLL_CTRL, 32'h0000_0000);
        rd(`ADDR_PLL_STATUS, 32'h0000_0000);
        rd(`ADDR_MAIN_OSC_CTRL, 32'h0000_0000);
        rd(`ADDR_WDOG_OSC_CTRL, 32'h0000_0000);
        chk({timer32_first_reset_n, dac_reset_n, pll_feedback_ratio, pll_post_ratio}, 13'h1822);
        $display("done reset");
    endtask
    task t_periph;
        wr(`ADDR_PERIPH_RESET_CTRL, 32'h0000_0000);
        chk({timer32_first_reset_n, dac_reset_n}, 2'h0);
        wr(`ADDR_PERIPH_RESET_CTRL, 32'hFFFF_FFFF, 4'h1);
        chk({timer32_first_reset_n, dac_reset_n}, 2'h2);
        rd(`ADDR_PERIPH_RESET_CTRL, 32'h0000_0080);
        wr(`ADDR_PERIPH_RESET_CTRL, 32'hFFFF_FFFF, 4'h2);
        rd(`ADDR_PERIPH_RESET_CTRL, 32'h0000_0480);
        chk({timer32_first_reset_n, dac_reset_n}, 2'h3);
        $display("done periph");
    endtask
    task t_pll;
        for (int p = 0; p < 4; p++) begin
            m = (p == 3) ? 5'h1F : 5'(p * 7);
            wr(`ADDR_PLL_CTRL, {25'h0, p[1:0], m});
            repeat (2) @(posedge clk);
            chk(pll_feedback_ratio, m + 6'h1);
            chk(pll_post_ratio, 5'h2 << p);
            rd(`ADDR_PLL_CTRL, {25'h0, p[1:0], m});
        end
        $display("done pll");
    endtask
    task t_status;
        pll_lock_in <= 1;
        wr(`ADDR_PLL_STATUS, 32'h0000_0000);
        rd(`ADDR_PLL_STATUS, 32'h0000_0001);
        pll_lock_in <= 0;
        wr(`ADDR_PLL_STATUS, 32'hFFFF_FFFF);
        rd(`ADDR_PLL_STATUS, 32'h0000_0000);
        wr(32'h4004_8010, 32'hFFFF_FFFF);
        rd(32'h4004_8010, 32'h0000_0000);
        $display("done status");
    endtask
    task t_osc;
        for (int v = 0; v < 4; v++) begin
            // The two sources are driven apart so the mux choice is visible.
            crystal_in_pin <= !v[1];
            osc_clk_in <= v[1];
            wr(`ADDR_MAIN_OSC_CTRL, {30'h3FFF_FFFF, v[1:0]});
            rd(`ADDR_MAIN_OSC_CTRL, v);
            chk(pll_in_clk, v[0] ? !v[1] : v[1]);
        end
        $display("done osc");
    endtask
    // The first interval is dropped, since a new select applies to an interval already in progress.
    task t_wdog(input logic [4:0] s);
        int n;
        logic v;
        wr(`ADDR_WDOG_OSC_CTRL, {23'h0, 4'h1, s});
        repeat (2) begin
            n = 0;
            v = wdog_osc_clk_out;
            // One edge more after each tick lets the output settle before it is read.
            do begin
                @(posedge clk) wdog_osc_analog_tick <= 1;
                @(posedge clk) wdog_osc_analog_tick <= 0;
                @(posedge clk);
                n++;
            end while (wdog_osc_clk_out === v);
        end
        chk(n, s + 1);
        $display("done wdog %0d", s);
    endtask
    task t_midreset;
        wr(`ADDR_PERIPH_RESET_CTRL, 32'h0000_0000);
        wr(`ADDR_PLL_CTRL, 32'h0000_007F);
        wr(`ADDR_MAIN_OSC_CTRL, 32'h0000_0003);
        resetn <= 0;
        repeat (2) @(posedge clk);
        resetn <= 1;
        t_reset;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1;
        t_reset;
        t_periph;
        t_pll;
        t_status;
        t_osc;
        t_wdog(5'h00);
        t_wdog(5'h03);
        t_wdog(5'h1F);
        t_midreset;
        summarize;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            summarize;
        end
    end
endmodule
bind sys_clock_reset_config sys_clock_reset_sva i_sva (
    .clk                   (clk),
    .resetn                (resetn),
    .address               (address),
    .read                  (read),
    .write                 (write),
    .byteenable            (byteenable),
    .writedata             (writedata),
    .readdata              (readdata),
    .waitrequest           (waitrequest),
    .timer32_first_reset_n (timer32_first_reset_n),
    .dac_reset_n           (dac_reset_n),
    .pll_feedback_div      (pll_feedback_div),
    .pll_post_div_sel      (pll_post_div_sel),
    .pll_feedback_ratio    (pll_feedback_ratio),
    .pll_post_ratio        (pll_post_ratio),
    .osc_bypass            (osc_bypass),
    .osc_range_sel         (osc_range_sel),
    .wdog_osc_div_sel      (wdog_osc_div_sel)
);
`default_nettype wire
